/* File: rtl/acs_regs.svh */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_MODE_MSB      6
`define ACS_MODE_LSB      4
`define ACS_CLKSEL_MSB    3
`define ACS_CLKSEL_LSB    2
`define ACS_MODE_RESET    3'h0
`define ACS_CLKSEL_RESET  2'h0
`define ACS_MODE_CONT     3'h0
`define ACS_MODE_SINGLE   3'h1
`define ACS_MODE_STANDBY  3'h2
`define ACS_MODE_PDOWN    3'h3
`define ACS_MODE_ZS_CAL   3'h6
`define ACS_MODE_FS_CAL   3'h7
`define ACS_CLK_INT       2'h0
`define ACS_CLK_INT_OUT   2'h1
`define ACS_CLK_EXT       2'h2
`define ACS_CAL_TIME_NS   1000
`define ACS_CLK_PERIOD_NS 10
`define ACS_CAL_CYCLES    ((`ACS_CAL_TIME_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)

`endif

/* File: rtl/acs_pkg.sv */
package acs_pkg;
  typedef struct packed {
    logic        valid;
    logic        gain;
    logic [1:0]  chan;
    logic [23:0] data;
  } acs_coef_t;

  typedef struct packed {
    logic int_osc_en;
    logic pin_drive;
    logic ext_sel;
  } acs_clk_t;
endpackage

/* File: rtl/acs_clk_sel.sv */
`include "acs_regs.svh"

module acs_clk_sel (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [1:0]       clk_sel,
  output acs_pkg::acs_clk_t     clk_ctl
);
  acs_pkg::acs_clk_t next_clk_ctl;

  always_comb begin
    next_clk_ctl = '0;
    unique case (clk_sel)
      `ACS_CLK_INT: next_clk_ctl.int_osc_en = 1'b1;
      `ACS_CLK_INT_OUT: begin
        next_clk_ctl.int_osc_en = 1'b1;
        next_clk_ctl.pin_drive  = 1'b1;
      end
      `ACS_CLK_EXT: next_clk_ctl.ext_sel = 1'b1;
      // Reserved code keeps the safe internal clock
      default: next_clk_ctl.int_osc_en = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_ctl <= '{int_osc_en: 1'b1, pin_drive: 1'b0, ext_sel: 1'b0};
    end else if (clk_en) begin
      clk_ctl <= next_clk_ctl;
    end
  end

  clk_decode_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en |=> (clk_ctl.ext_sel == ($past(clk_sel) == `ACS_CLK_EXT)))
    else $error("clock select decode wrong");
  clk_drive_a: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_ctl.pin_drive |-> clk_ctl.int_osc_en && !clk_ctl.ext_sel)
    else $error("pin driven without internal clock");
endmodule

/* File: rtl/acs_ctrl.sv */
// Functional notes
// - Mode field at bits 6:4; code 010 holds the converter in standby.
// - Mode 110 with exactly one channel enabled runs zero-scale calibration, stores offset, then standby.
// - Mode 111 with exactly one channel enabled runs full-scale calibration, stores gain, then standby.
// - Clock select at bits 3:2, resets to 00: internal oscillator.
// - Code 01: internal oscillator, also driven out on shared clock pin.
// - Code 10: converter clock taken from the shared clock pin.
`include "acs_regs.svh"

module acs_ctrl (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              cfg_write,
  input  wire logic [10:0]       cfg_data,
  input  wire logic [3:0]        chan_en,
  input  wire logic [23:0]       sample,
  input  wire logic              shared_clock_pin_in,
  output logic                   shared_clock_pin_out,
  output logic                   shared_clock_pin_oe,
  output logic                   conv_clk_ext,
  output logic                   busy,
  output logic                   cal_error,
  output logic [2:0]             mode_now,
  output acs_pkg::acs_coef_t     coef_wr
);
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_CAL  = 3'b010,
    ACS_DONE = 3'b100
  } acs_state_t;

  function automatic logic one_hot4(input logic [3:0] v);
    one_hot4 = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  function automatic logic [1:0] chan_idx(input logic [3:0] v);
    chan_idx = v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
  endfunction

  localparam int CAL_CYC = `ACS_CAL_CYCLES;

  acs_state_t         state;
  acs_state_t         next_state;
  logic [2:0]         next_mode;
  logic [1:0]         clk_sel;
  logic [1:0]         next_clk_sel;
  logic [7:0]         cnt;
  logic [7:0]         next_cnt;
  logic               gain_cal;
  logic               next_gain_cal;
  logic               next_busy;
  logic               next_err;
  logic               osc_div;
  logic               next_osc_div;
  acs_pkg::acs_coef_t next_coef;
  acs_pkg::acs_clk_t  clk_ctl;

  acs_clk_sel u_clk_sel (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .clk_sel (clk_sel),
    .clk_ctl (clk_ctl)
  );

  always_comb begin
    next_state    = state;
    next_mode     = mode_now;
    next_clk_sel  = clk_sel;
    next_cnt      = cnt;
    next_gain_cal = gain_cal;
    next_busy     = busy;
    next_err      = cal_error;
    next_coef     = '0;
    // Writes during calibration are dropped so a result is never torn
    if (cfg_write && state == ACS_IDLE) begin
      next_mode    = cfg_data[`ACS_MODE_MSB:`ACS_MODE_LSB];
      next_clk_sel = cfg_data[`ACS_CLKSEL_MSB:`ACS_CLKSEL_LSB];
      if (next_mode == `ACS_MODE_ZS_CAL || next_mode == `ACS_MODE_FS_CAL) begin
        if (one_hot4(chan_en)) begin
          next_state    = ACS_CAL;
          next_cnt      = 8'(CAL_CYC - 1);
          next_gain_cal = next_mode[0];
          next_busy     = 1'b1;
          next_err      = 1'b0;
        end else begin
          next_err  = 1'b1;
          next_mode = `ACS_MODE_STANDBY;
        end
      end
    end
    unique case (state)
      ACS_IDLE: ;
      ACS_CAL: begin
        if (cnt == 8'h0) begin
          next_state = ACS_DONE;
        end else begin
          next_cnt = cnt - 8'h1;
        end
      end
      ACS_DONE: begin
        // offset or gain coefficient, then standby
        next_coef.valid = 1'b1;
        next_coef.gain  = gain_cal;
        next_coef.chan  = chan_idx(chan_en);
        next_coef.data  = sample;
        next_mode       = `ACS_MODE_STANDBY;
        next_busy       = 1'b0;
        next_state      = ACS_IDLE;
      end
    endcase
  end

  always_comb begin
    next_osc_div = clk_ctl.int_osc_en ? ~osc_div : 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ACS_IDLE;
      mode_now  <= `ACS_MODE_RESET;
      clk_sel   <= `ACS_CLKSEL_RESET;
      cnt       <= 8'h0;
      gain_cal  <= 1'b0;
      busy      <= 1'b0;
      cal_error <= 1'b0;
      coef_wr   <= '0;
      osc_div   <= 1'b0;
    end else if (clk_en) begin
      state     <= next_state;
      mode_now  <= next_mode;
      clk_sel   <= next_clk_sel;
      cnt       <= next_cnt;
      gain_cal  <= next_gain_cal;
      busy      <= next_busy;
      cal_error <= next_err;
      coef_wr   <= next_coef;
      osc_div   <= next_osc_div;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shared_clock_pin_out <= 1'b0;
      shared_clock_pin_oe  <= 1'b0;
      conv_clk_ext         <= 1'b0;
    end else if (clk_en) begin
      shared_clock_pin_out <= clk_ctl.pin_drive & next_osc_div;
      shared_clock_pin_oe  <= clk_ctl.pin_drive;
      conv_clk_ext         <= clk_ctl.ext_sel & shared_clock_pin_in;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  cal_ends_a: assert property (
    (state == ACS_DONE) && clk_en |=>
    mode_now == `ACS_MODE_STANDBY && coef_wr.valid && !busy)
    else $error("calibration did not end in standby");
  gain_kind_a: assert property (
    coef_wr.valid |-> coef_wr.gain == gain_cal)
    else $error("coefficient kind wrong");
  one_chan_a: assert property (
    $rose(busy) |-> $past(one_hot4(chan_en)))
    else $error("calibration began without one channel");
  standby_hold_a: assert property (
    mode_now == `ACS_MODE_STANDBY && !cfg_write && state == ACS_IDLE
    |=> mode_now == `ACS_MODE_STANDBY)
    else $error("standby left without write");
  pin_oe_a: assert property (
    clk_en && clk_sel == `ACS_CLK_INT_OUT && $stable(clk_sel)
    |=> ##1 shared_clock_pin_oe)
    else $error("pin not driven");
  int_only_a: assert property (
    clk_en && clk_sel == `ACS_CLK_INT && $stable(clk_sel)
    |=> ##1 !shared_clock_pin_oe && !conv_clk_ext)
    else $error("internal clock leaked");
  ext_off_a: assert property (
    conv_clk_ext |-> $past(clk_ctl.ext_sel))
    else $error("external clock taken while not selected");
  cal_len_a: assert property (
    $rose(busy) |-> busy [*8])
    else $error("calibration too short");

  // One-cycle strobe, so a sink never stores a result twice
  coef_pulse_a: assert property (
    coef_wr.valid && clk_en |=> !coef_wr.valid)
    else $error("coefficient strobe held");
  // Writes while busy are dropped, so the mode holds
  cal_mode_a: assert property (
    state == ACS_CAL && clk_en |=> $stable(mode_now))
    else $error("mode changed during calibration");
  bad_chan_a: assert property (
    cfg_write && clk_en && state == ACS_IDLE &&
    cfg_data[`ACS_MODE_MSB:`ACS_MODE_MSB-1] == 2'h3 && !one_hot4(chan_en)
    |=> cal_error && !busy && mode_now == `ACS_MODE_STANDBY)
    else $error("bad channel set not refused");
  cal_start_a: assert property (
    cfg_write && clk_en && state == ACS_IDLE &&
    cfg_data[`ACS_MODE_MSB:`ACS_MODE_MSB-1] == 2'h3 && one_hot4(chan_en)
    |=> busy && state == ACS_CAL &&
    mode_now == $past(cfg_data[`ACS_MODE_MSB:`ACS_MODE_LSB]))
    else $error("calibration not started");
  ext_no_drive_a: assert property (
    clk_en && clk_ctl.ext_sel |=> !shared_clock_pin_oe)
    else $error("pin driven while taking external clock");

  zs_cov: cover property (coef_wr.valid && !coef_wr.gain);
  fs_cov: cover property (coef_wr.valid && coef_wr.gain);
  err_cov: cover property ($rose(cal_error));
  ext_cov: cover property (conv_clk_ext);
  end_cov: cover property ($fell(busy));
endmodule

/* File: test/adc_calibration_clock_select_tb_top.sv */
module adc_calibration_clock_select_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic               clk_sys = 1'b0;
  logic               reset_n = 1'b0;
  logic               clk_en = 1'b1;
  logic               cfg_write = 1'b0;
  logic [10:0]        cfg_data = 11'h000;
  logic [3:0]         chan_en = 4'h1;
  logic [23:0]        sample = 24'h000000;
  logic               pin_in = 1'b0;
  logic               pin_out;
  logic               pin_oe;
  logic               clk_ext;
  logic               busy;
  logic               cal_error;
  logic [2:0]         mode_now;
  acs_pkg::acs_coef_t coef_wr;
  logic               prev;
  int                 err_count = 0;
  int                 checks = 0;
  int                 cycles = 0;

  acs_ctrl uut (
    .clk_sys              (clk_sys),
    .reset_n              (reset_n),
    .clk_en               (clk_en),
    .cfg_write            (cfg_write),
    .cfg_data             (cfg_data),
    .chan_en              (chan_en),
    .sample               (sample),
    .shared_clock_pin_in  (pin_in),
    .shared_clock_pin_out (pin_out),
    .shared_clock_pin_oe  (pin_oe),
    .conv_clk_ext         (clk_ext),
    .busy                 (busy),
    .cal_error            (cal_error),
    .mode_now             (mode_now),
    .coef_wr              (coef_wr)
  );

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cut a hang short well past the expected few hundred cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Returns just after the edge that took the word
  task automatic wr(input logic [2:0] m, input logic [1:0] c);
    @(posedge clk_sys);
    #1;
    cfg_write = 1'b1;
    cfg_data = {4'h0, m, c, 2'h0};
    step(1);
    cfg_write = 1'b0;
  endtask

  task automatic t_reset;
    chk(mode_now, 3'h0);
    chk({pin_oe, clk_ext, busy, cal_error}, 4'h0);
    chk(coef_wr, 28'h0);
  endtask

  // Frozen write must not land
  task automatic t_mode;
    clk_en = 1'b0;
    wr(3'h2, 2'h1);
    chk(mode_now, 3'h0);
    clk_en = 1'b1;
    wr(3'h2, 2'h1);
    chk(mode_now, 3'h2);
  endtask

  task automatic t_clock;
    pin_in = 1'b1;
    step(2);
    chk(pin_oe, 1'h1);
    prev = pin_out;
    step(1);
    chk(pin_out, 1'(~prev));
    wr(3'h2, 2'h2);
    step(3);
    chk({pin_oe, clk_ext}, 2'h1);
    pin_in = 1'b0;
    step(3);
    chk(clk_ext, 1'h0);
    pin_in = 1'b1;
    wr(3'h2, 2'h3);
    step(3);
    chk({pin_oe, clk_ext}, 2'h0);
    wr(3'h2, 2'h0);
    step(3);
    chk({pin_oe, clk_ext}, 2'h0);
  endtask

  task automatic t_bad;
    chan_en = 4'h3;
    wr(3'h7, 2'h1);
    step(1);
    chk({cal_error, busy, mode_now}, {2'h2, 3'h2});
  endtask

  task automatic t_cal(input logic [2:0] m, input logic [3:0] en,
                       input logic [1:0] ch, input logic g);
    int n;
    n = 0;
    chan_en = en;
    sample = {20'hA5C30, en};
    wr(m, 2'h1);
    chk({busy, mode_now}, {1'h1, m});
    // A write while busy is dropped
    wr(3'h0, 2'h1);
    chk(mode_now, m);
    while (coef_wr.valid !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
    chk(coef_wr, {1'h1, g, ch, sample});
    step(1);
    chk({busy, cal_error, coef_wr.valid, mode_now}, 6'h02);
  endtask

  initial begin
    step(20);
    t_reset();
    reset_n = 1'b1;
    t_mode();
    t_clock();
    t_bad();
    t_cal(3'h6, 4'h4, 2'h2, 1'b0);
    t_cal(3'h7, 4'h8, 2'h3, 1'b1);
    summarize();
  end
endmodule
